// file: verilog/vcm_matrix.sv
`timescale 1ns/1ns
`default_nettype none
module vcm_matrix
  import vcm_pkg::*;
#(
  parameter int NUM_IN = 4,
  parameter int NUM_OUT = 4,
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Incoming path signals, one lane per input point
  input wire logic [NUM_IN*BYTE_W-1:0] path_signal_data,
  input wire logic [NUM_IN-1:0] path_signal_clock,
  input wire logic [NUM_IN-1:0] path_signal_frame_start,
  input wire logic [NUM_IN-1:0] path_server_fail_flag,
  input wire logic [NUM_IN-1:0] adapted_trail_fail_flag,
  input wire logic [NUM_IN-1:0] adapted_trail_degrade_flag,
  // Common timing
  input wire logic common_timing_clock,
  input wire logic common_timing_frame_start,
  // Outgoing path signals, one lane per output point
  output logic [NUM_OUT*BYTE_W-1:0] out_path_signal_data,
  output logic [NUM_OUT-1:0] out_path_signal_clock,
  output logic [NUM_OUT-1:0] out_path_signal_frame_start,
  output logic [NUM_OUT-1:0] out_path_server_fail_flag
);
  typedef struct packed {
    logic [1:0][NUM_IN*BYTE_W-1:0] s_d;
    logic [1:0][NUM_IN-1:0] s_ck;
    logic [1:0][NUM_IN-1:0] s_fs;
    logic [1:0][NUM_IN-1:0] s_ssf;
    logic [1:0][NUM_IN-1:0] s_tsf;
    logic [1:0][NUM_IN-1:0] s_tsd;
    logic [1:0] s_tck;
    logic [1:0] s_tfs;
    logic [NUM_IN-1:0] ck_d;
    logic tck_d;
    logic tfs_d;
    logic [NUM_IN*BYTE_W-1:0] c_d;
    logic [NUM_IN-1:0] c_fs;
    logic [NUM_OUT-1:0][CONN_W-1:0] shadow;
    logic [NUM_OUT-1:0][CONN_W-1:0] active;
    vcm_kind_t kind;
    logic rev;
    logic [HOLD_W-1:0] hold;
    logic [WTR_W-1:0] wait_to_restore;
    logic cmd_v;
    logic [CMD_W-1:0] cmd;
    logic [IDX_W-1:0] grp;
    logic [31:0] tick_cnt;
    logic tick;
    logic [NUM_OUT*BYTE_W-1:0] o_d;
    logic [NUM_OUT-1:0] o_ck;
    logic [NUM_OUT-1:0] o_fs;
    logic [NUM_OUT-1:0] o_ssf;
    logic [31:0] rd;
    logic err;
  } vcm_mx_t;

  vcm_mx_t r;
  vcm_mx_t next_r;
  logic fs_edge;
  logic [NUM_OUT-1:0] sel_vec;
  logic [NUM_OUT-1:0] busy_vec;
  logic [IDX_W-1:0] src;
  logic [IDX_W-1:0] ridx;
  logic [IDX_W-1:0] widx;
  vcm_dec_t rdec;
  vcm_dec_t wdec;
  ////////////////////////////////////////////////////////////////////////
  function automatic vcm_dec_t decode(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'h0) return DEC_NONE;
    else if (int'(a) < int'(ADDR_CONN0) + NUM_OUT * REG_BYTES) return DEC_CONN;
    else if (a == ADDR_PROT) return DEC_PROT;
    else if (a == ADDR_CMD) return DEC_CMD;
    else if (a == ADDR_STAT) return DEC_STAT;
    else return DEC_NONE;
  endfunction

  function automatic logic [IDX_W-1:0] conn_work(input logic [CONN_W-1:0] c);
    return c[CONN_WORK_LSB +: IDX_W];
  endfunction

  function automatic logic [IDX_W-1:0] conn_prot(input logic [CONN_W-1:0] c);
    return c[CONN_PROT_LSB +: IDX_W];
  endfunction

  // Criteria follow the protection kind
  function automatic logic fail_of(input vcm_kind_t k, input logic server_signal_fail, input logic trail_signal_fail);
    return (k == KIND_INHERENT) ? server_signal_fail : trail_signal_fail;
  endfunction

  function automatic logic deg_of(input vcm_kind_t k, input logic trail_signal_degrade);
    return (k == KIND_INHERENT) ? 1'b0 : trail_signal_degrade;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Frame boundary of the common timing, seen after the synchroniser
  assign fs_edge = r.s_tfs[1] && !r.tfs_d;
  assign ridx = paddr[IDX_W+1:2];
  assign widx = paddr[IDX_W+1:2];
  assign rdec = decode(paddr);
  assign wdec = decode(paddr);

  always_comb begin
    next_r = r;
    src = '0;
    // Every path and timing pin passes two flops before anything looks at it
    next_r.s_d = {r.s_d[0], path_signal_data};
    next_r.s_ck = {r.s_ck[0], path_signal_clock};
    next_r.s_fs = {r.s_fs[0], path_signal_frame_start};
    next_r.s_ssf = {r.s_ssf[0], path_server_fail_flag};
    next_r.s_tsf = {r.s_tsf[0], adapted_trail_fail_flag};
    next_r.s_tsd = {r.s_tsd[0], adapted_trail_degrade_flag};
    next_r.s_tck = {r.s_tck[0], common_timing_clock};
    next_r.s_tfs = {r.s_tfs[0], common_timing_frame_start};
    next_r.ck_d = r.s_ck[1];
    next_r.tck_d = r.s_tck[1];
    next_r.tfs_d = r.s_tfs[1];
    // Each lane's byte and frame marker are taken on its own clock's rising edge
    for (int i = 0; i < NUM_IN; i++) begin
      if (r.s_ck[1][i] && !r.ck_d[i]) begin
        next_r.c_d[i*BYTE_W +: BYTE_W] = r.s_d[1][i*BYTE_W +: BYTE_W];
        next_r.c_fs[i] = r.s_fs[1][i];
      end
    end
    // Coarse tick that paces hold-off and restore wait
    next_r.tick = 1'b0;
    if (r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
    end
    // Staged connections go live together, so both legs of a bridge move at once
    if (fs_edge) next_r.active = r.shadow;
    ////////////////////////////////////////////////////////////////////////
    for (int k = 0; k < NUM_OUT; k++) begin
      src = sel_vec[k] ? conn_prot(r.active[k]) : conn_work(r.active[k]);
      if (r.active[k][CONN_EN_BIT] && int'(src) < NUM_IN) begin
        next_r.o_d[k*BYTE_W +: BYTE_W] = r.c_d[src*BYTE_W +: BYTE_W];
        next_r.o_ck[k] = r.ck_d[src];
        next_r.o_fs[k] = r.c_fs[src];
        next_r.o_ssf[k] = r.s_ssf[1][src];
      end else begin
        // Unequipped filler: all-zero bytes, so the tandem byte is zero too
        next_r.o_d[k*BYTE_W +: BYTE_W] = UNEQ_BYTE;
        next_r.o_ck[k] = r.tck_d;
        next_r.o_fs[k] = r.tfs_d;
        next_r.o_ssf[k] = 1'b0;
      end
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data is latched in the setup cycle so prdata comes from a flop
    next_r.cmd_v = 1'b0;
    if (psel && !penable) begin
      next_r.rd = '0;
      next_r.err = 1'b0;
      if (rdec == DEC_CONN) begin
        next_r.rd[CONN_W-1:0] = r.shadow[ridx];
      end else if (rdec == DEC_PROT) begin
        next_r.rd[PROT_KIND_LSB +: 2] = r.kind;
        next_r.rd[PROT_REV_BIT] = r.rev;
        next_r.rd[PROT_HOLD_LSB +: HOLD_W] = r.hold;
        next_r.rd[PROT_WTR_LSB +: WTR_W] = r.wait_to_restore;
      end else if (rdec == DEC_CMD) begin
        next_r.rd = '0;
      end else if (rdec == DEC_STAT) begin
        for (int k = 0; k < NUM_OUT; k++) begin
          next_r.rd[2*k] = sel_vec[k];
          next_r.rd[2*k+1] = busy_vec[k];
        end
      end else begin
        next_r.err = 1'b1;
      end
    end
    if (psel && penable && pwrite) begin
      if (wdec == DEC_CONN) begin
        // Staged only; live traffic is untouched until the next frame start
        next_r.shadow[widx] = pwdata[CONN_W-1:0];
      end else if (wdec == DEC_PROT) begin
        // Timers and mode apply live; they only pace future decisions
        next_r.kind = vcm_kind_t'(pwdata[PROT_KIND_LSB +: 2]);
        next_r.rev = pwdata[PROT_REV_BIT];
        next_r.wait_to_restore = pwdata[PROT_WTR_LSB +: WTR_W];
        if (pwdata[PROT_HOLD_LSB +: HOLD_W] > HOLD_MAX) next_r.hold = HOLD_MAX;
        else next_r.hold = pwdata[PROT_HOLD_LSB +: HOLD_W];
      end else if (wdec == DEC_CMD) begin
        next_r.cmd_v = 1'b1;
        next_r.cmd = pwdata[CMD_CODE_LSB +: CMD_W];
        next_r.grp = pwdata[CMD_GRP_LSB +: IDX_W];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '{kind: KIND_INHERENT, rev: PROT_REV_RST, wait_to_restore: WTR_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rd;
  assign pready = psel && penable;
  assign pslverr = psel && penable && r.err;
  assign out_path_signal_data = r.o_d;
  assign out_path_signal_clock = r.o_ck;
  assign out_path_signal_frame_start = r.o_fs;
  assign out_path_server_fail_flag = r.o_ssf;
  ////////////////////////////////////////////////////////////////////////
  // One 1+1 selector per output; no signalling channel, no extra traffic
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_grp
      logic [IDX_W-1:0] wi;
      logic [IDX_W-1:0] pi;
      assign wi = conn_work(r.active[g]);
      assign pi = conn_prot(r.active[g]);
      vcm_snc_sel u_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(r.tick),
        .frame_edge(fs_edge),
        .protected_en(r.active[g][CONN_EN_BIT] && r.active[g][CONN_PROTD_BIT]),
        .revertive_select(r.rev),
        .holdoff_delay(r.hold),
        .restore_wait_period(r.wait_to_restore),
        .fail_w(fail_of(r.kind, r.s_ssf[1][wi], r.s_tsf[1][wi])),
        .deg_w(deg_of(r.kind, r.s_tsd[1][wi])),
        .fail_p(fail_of(r.kind, r.s_ssf[1][pi], r.s_tsf[1][pi])),
        .deg_p(deg_of(r.kind, r.s_tsd[1][pi])),
        .cmd_valid(r.cmd_v && r.grp == IDX_W'(g)),
        .external_switch_command(r.cmd),
        .sel_prot(sel_vec[g]),
        .busy(busy_vec[g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  property p_uneq_out;
    @(posedge sys_clk) disable iff (!rst_n)
      !r.active[0][CONN_EN_BIT] |=>
        (out_path_signal_data[BYTE_W-1:0] == UNEQ_BYTE && !out_path_server_fail_flag[0]);
  endproperty
  a_uneq_out: assert property (p_uneq_out) else $error("idle output not unequipped");
  property p_uneq_fs;
    @(posedge sys_clk) disable iff (!rst_n)
      !r.active[0][CONN_EN_BIT] |=> out_path_signal_frame_start[0] == $past(r.tfs_d);
  endproperty
  a_uneq_fs: assert property (p_uneq_fs) else $error("unequipped frame start wrong");
  property p_apply_frame;
    @(posedge sys_clk) disable iff (!rst_n) $changed(r.active) |-> $past(fs_edge);
  endproperty
  a_apply_frame: assert property (p_apply_frame) else $error("connection moved off frame");
  property p_conn_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (psel && penable && pwrite && paddr == ADDR_CONN0) |=>
        r.shadow[0] == $past(pwdata[CONN_W-1:0]);
  endproperty
  a_conn_write: assert property (p_conn_write) else $error("connection write lost");
  property p_bridge;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.active[0] == r.active[1] && r.active[0][CONN_EN_BIT]
       && !r.active[0][CONN_PROTD_BIT]) |=>
        out_path_signal_data[BYTE_W-1:0] == out_path_signal_data[2*BYTE_W-1:BYTE_W];
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridged legs differ");
endmodule
`default_nettype wire

// file: verilog/vcm_pkg.sv
// Notes on behaviour
// - Any input can be connected to any output, and disconnected again.
// - Connections hold kind (plain or 1+1 protected), direction and point ids.
// - Broadcast is several connections sharing one input.
// - Reconfiguring protection, legs or timers leaves idle traffic undisturbed.
// - An unequipped VC-12 generator is built in.
// - Unconnected outputs carry unequipped signal, valid frame start, no fail.
// - Linear subnetwork protection groups are optional per connection.
// - Protection is 1+1, no signalling channel, no extra traffic.
// - Sink selects working or protection from fail, degrade and commands.
// - Source bridges the normal input permanently to working and protection outputs.
// - Inherent kind uses server fail; other kinds use trail fail and degrade.
// - Revertive and non-revertive supported; restore wait about 5 to 12 minutes.
// - Hold-off programmable 0 to 10 seconds in 100 ms steps.
// - Revertive takes barred, forced, manual, clear; non-revertive targets either channel.
// - Signals are byte streams in 500 us frames marked by frame start.
// - Unequipped signal carries an all-zero tandem connection byte.
`default_nettype none
package vcm_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int HOLD_MAX_MS = 10000;
  localparam int WTR_MIN_MS = 300000;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 2;
  localparam int CMD_W = 3;
  localparam int HOLD_W = 7;
  localparam int WTR_W = 13;
  localparam int CONN_W = 7;
  localparam int ADDR_W = 8;
  localparam int REG_BYTES = 4;
  localparam logic [HOLD_W-1:0] HOLD_MAX = HOLD_W'(HOLD_MAX_MS / TICK_MS);
  localparam logic [WTR_W-1:0] WTR_RST = WTR_W'(WTR_MIN_MS / TICK_MS);
  localparam logic PROT_REV_RST = 1'b1;
  localparam logic [BYTE_W-1:0] UNEQ_BYTE = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [ADDR_W-1:0] ADDR_CONN0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PROT = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h18;
  localparam int CONN_WORK_LSB = 0;
  localparam int CONN_PROT_LSB = 2;
  localparam int CONN_EN_BIT = 4;
  localparam int CONN_PROTD_BIT = 5;
  localparam int CONN_BIDIR_BIT = 6;
  localparam int PROT_KIND_LSB = 0;
  localparam int PROT_REV_BIT = 2;
  localparam int PROT_HOLD_LSB = 4;
  localparam int PROT_WTR_LSB = 16;
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_GRP_LSB = 4;
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    KIND_INHERENT = 2'h0,
    KIND_NONINTRUSIVE = 2'h1,
    KIND_SUBLAYER = 2'h2
  } vcm_kind_t;
  typedef enum logic [CMD_W-1:0] {
    CMD_CLEAR = 3'h0,
    CMD_BARRED = 3'h1,
    CMD_FORCE_P = 3'h2,
    CMD_FORCE_W = 3'h3,
    CMD_MANUAL_P = 3'h4,
    CMD_MANUAL_W = 3'h5
  } vcm_cmd_t;
  typedef enum logic [2:0] {
    DEC_NONE = 3'h0,
    DEC_CONN = 3'h1,
    DEC_PROT = 3'h2,
    DEC_CMD = 3'h3,
    DEC_STAT = 3'h4
  } vcm_dec_t;
endpackage
`default_nettype wire

// file: verilog/vcm_snc_sel.sv
`timescale 1ns/1ns
`default_nettype none
module vcm_snc_sel
  import vcm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Timing
  input wire logic tick,
  input wire logic frame_edge,
  // Group settings
  input wire logic protected_en,
  input wire logic revertive_select,
  input wire logic [HOLD_W-1:0] holdoff_delay,
  input wire logic [WTR_W-1:0] restore_wait_period,
  // Channel conditions
  input wire logic fail_w,
  input wire logic deg_w,
  input wire logic fail_p,
  input wire logic deg_p,
  // External command
  input wire logic cmd_valid,
  input wire logic [CMD_W-1:0] external_switch_command,
  // Result
  output logic sel_prot,
  output logic busy
);
  typedef enum logic [2:0] {
    SS_WORK = 3'b001,
    SS_PROT = 3'b010,
    SS_WTR = 3'b100
  } vcm_sel_st_t;
  typedef struct packed {
    vcm_sel_st_t st;
    vcm_cmd_t cmd;
    logic [HOLD_W-1:0] hold_w;
    logic [HOLD_W-1:0] hold_p;
    logic [WTR_W-1:0] wtr_cnt;
    logic sel;
  } vcm_sel_t;
  vcm_sel_t r;
  vcm_sel_t next_r;
  logic sf_w, sd_w, sf_p, sd_p, has_req, want_p;
  vcm_cmd_t cmd_in;
  assign cmd_in = vcm_cmd_t'(external_switch_command);
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    // Conditions count whole ticks before they are believed
    if (!(fail_w || deg_w)) next_r.hold_w = '0;
    else if (tick && r.hold_w < holdoff_delay) next_r.hold_w = r.hold_w + 1'b1;
    if (!(fail_p || deg_p)) next_r.hold_p = '0;
    else if (tick && r.hold_p < holdoff_delay) next_r.hold_p = r.hold_p + 1'b1;
    sf_w = fail_w && (r.hold_w >= holdoff_delay);
    sd_w = deg_w && (r.hold_w >= holdoff_delay);
    sf_p = fail_p && (r.hold_p >= holdoff_delay);
    sd_p = deg_p && (r.hold_p >= holdoff_delay);
    if (cmd_valid) begin
      if (cmd_in == CMD_CLEAR) next_r.cmd = CMD_CLEAR;
      else if (!(revertive_select && (cmd_in == CMD_FORCE_W || cmd_in == CMD_MANUAL_W)))
        next_r.cmd = cmd_in;
    end
    has_req = 1'b1;
    want_p = 1'b0;
    if (r.cmd == CMD_BARRED) want_p = 1'b0;
    else if (r.cmd == CMD_FORCE_P) want_p = 1'b1;
    else if (r.cmd == CMD_FORCE_W) want_p = 1'b0;
    else if (sf_w && !sf_p) want_p = 1'b1;
    else if (sf_p) want_p = 1'b0;
    else if (sd_w && !sd_p) want_p = 1'b1;
    else if (sd_p) want_p = 1'b0;
    else if (r.cmd == CMD_MANUAL_P) want_p = 1'b1;
    else if (r.cmd == CMD_MANUAL_W) want_p = 1'b0;
    else has_req = 1'b0;
    if (!protected_en) begin
      next_r.st = SS_WORK;
      next_r.cmd = CMD_CLEAR;
    end else if (has_req) begin
      next_r.st = want_p ? SS_PROT : SS_WORK;
      next_r.wtr_cnt = '0;
    end else begin
      case (r.st)
        SS_PROT: begin
          if (revertive_select) begin
            next_r.st = SS_WTR;
            next_r.wtr_cnt = '0;
          end
        end
        SS_WTR: begin
          if (!revertive_select) begin
            next_r.st = SS_PROT;
          end else if (tick) begin
            next_r.wtr_cnt = r.wtr_cnt + 1'b1;
            if (next_r.wtr_cnt >= restore_wait_period) next_r.st = SS_WORK;
          end
        end
        SS_WORK: ;
        default: next_r.st = SS_WORK;
      endcase
    end
    // A switch mid-frame would hand a torn frame downstream
    if (frame_edge) next_r.sel = (next_r.st != SS_WORK);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) r <= '{st: SS_WORK, cmd: CMD_CLEAR, default: '0};
    else r <= next_r;
  end

  assign sel_prot = r.sel;
  assign busy = (r.st != SS_WORK) || (r.cmd != CMD_CLEAR);
  ////////////////////////////////////////////////////////////////////////
  property p_unprot_work;
    @(posedge sys_clk) disable iff (!rst_n) (!protected_en && frame_edge) |=> !sel_prot;
  endproperty
  a_unprot_work: assert property (p_unprot_work) else $error("unprotected leg left on protection");
  property p_sel_at_frame;
    @(posedge sys_clk) disable iff (!rst_n) $changed(sel_prot) |-> $past(frame_edge);
  endproperty
  a_sel_at_frame: assert property (p_sel_at_frame) else $error("selector moved off a frame start");
  property p_barred;
    @(posedge sys_clk) disable iff (!rst_n)
      (protected_en && r.cmd == CMD_BARRED && frame_edge) |=> !sel_prot;
  endproperty
  a_barred: assert property (p_barred) else $error("barred group not on working");
  property p_forced;
    @(posedge sys_clk) disable iff (!rst_n)
      (protected_en && r.cmd == CMD_FORCE_P && frame_edge) |=> sel_prot;
  endproperty
  a_forced: assert property (p_forced) else $error("forced switch not on protection");
  // A command already on its way may move the selector at once, hold-off or not
  property p_holdoff;
    @(posedge sys_clk) disable iff (!rst_n)
      (protected_en && r.st == SS_WORK && r.cmd == CMD_CLEAR && r.hold_w == '0
       && holdoff_delay > 7'h01 && !fail_p && !deg_p && !cmd_valid) |=> r.st == SS_WORK [*2];
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("switched inside hold-off");
  property p_fail_switch;
    @(posedge sys_clk) disable iff (!rst_n)
      (protected_en && r.cmd == CMD_CLEAR && sf_w && !fail_p && !deg_p) |=> r.st == SS_PROT;
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("working fail not switched");
  property p_wtr_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (protected_en && r.st == SS_WTR && revertive_select && !tick && !fail_p && !deg_p
       && r.cmd == CMD_CLEAR) |=> r.st != SS_WORK;
  endproperty
  a_wtr_hold: assert property (p_wtr_hold) else $error("reverted before restore wait");
endmodule
`default_nettype wire

// file: verif/vcm_lane_src.sv
`timescale 1ns/1ns
`default_nettype none
module vcm_lane_src
  import vcm_pkg::*;
#(
  parameter int LANES = 4,
  parameter int FRAME_BYTES = 8
) (
  // Lanes and common timing
  output logic [LANES*BYTE_W-1:0] data,
  output logic [LANES-1:0] lclk,
  output logic [LANES-1:0] fs,
  output logic tclk,
  output logic tfs
);
  logic [5:0] cnt;
  // Line clocks run free; lane id in the top bits names the source of a routed byte
  initial begin
    cnt = 6'h00;
    data = '0;
    lclk = '0;
    fs = '0;
    tclk = 1'b0;
    tfs = 1'b0;
    #1;
    forever begin
      #32;
      lclk = '1;
      tclk = 1'b1;
      #32;
      lclk = '0;
      tclk = 1'b0;
      cnt = cnt + 6'h01;
      for (int i = 0; i < LANES; i++) begin
        data[i*BYTE_W +: BYTE_W] = {i[1:0], cnt};
      end
      fs = (cnt % FRAME_BYTES == 0) ? '1 : '0;
      tfs = (cnt % FRAME_BYTES == 0);
    end
  end
endmodule
`default_nettype wire

// file: verif/vc12_connection_matrix_snc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module vc12_connection_matrix_snc_tb_top
  import vcm_pkg::*;
;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, e, tck, tfs;
  logic fs_seen = 1'b0;
  logic ck_seen = 1'b0;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q, id, od;
  logic [3:0] server_signal_fail, trail_signal_fail, trail_signal_degrade, ick, ifs, ock, ofs, ossf;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  vcm_matrix #(.NUM_IN(4), .NUM_OUT(4), .TICK_CYCLES(8)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .path_signal_data(id), .path_signal_clock(ick), .path_signal_frame_start(ifs),
    .path_server_fail_flag(server_signal_fail), .adapted_trail_fail_flag(trail_signal_fail),
    .adapted_trail_degrade_flag(trail_signal_degrade), .common_timing_clock(tck),
    .common_timing_frame_start(tfs), .out_path_signal_data(od), .out_path_signal_clock(ock),
    .out_path_signal_frame_start(ofs), .out_path_server_fail_flag(ossf));
  vcm_lane_src #(.LANES(4), .FRAME_BYTES(8)) i_src (
    .data(id), .lclk(ick), .fs(ifs), .tclk(tck), .tfs(tfs));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic x);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(32'(q[0]), 32'(x));
  endtask
  task automatic ln(input int k, input logic [1:0] x);
    chk(32'(od[8*k+6 +: 2]), 32'(x));
  endtask
  // Changes land on a common frame boundary, so wait whole frames
  task automatic wfr(input int n);
    repeat (n) @(posedge tfs);
    repeat (8) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (ofs[3] === 1'b1) begin
      fs_seen <= 1'b1;
    end
    if (ock[3] === 1'b1) begin
      ck_seen <= 1'b1;
    end
    if (cyc == 30000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite} = '0;
    {paddr, pwdata, server_signal_fail, trail_signal_fail, trail_signal_degrade} = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    wfr(2);
    st(1'b0);
    chk(od, 32'h0);
    chk(32'(ossf), 32'h0);
    chk(32'(fs_seen), 32'h1);
    chk(32'(ck_seen), 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h02, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, ADDR_CONN0, 32'h12);
    apb(1'b1, ADDR_CONN0 + 8'h04, 32'h12);
    wfr(2);
    ln(0, 2'h2);
    ln(1, 2'h2);
    server_signal_fail[2] <= 1'b1;
    wfr(1);
    chk(32'(ossf[1:0]), 32'h3);
    server_signal_fail[2] <= 1'b0;
    apb(1'b1, ADDR_CONN0 + 8'h04, 32'h0);
    wfr(2);
    ln(1, 2'h0);
    apb(1'b1, ADDR_PROT, 32'h00040044);
    apb(1'b0, ADDR_PROT, 32'h0);
    chk(q, 32'h00040044);
    chk(32'(e), 32'h0);
    ln(0, 2'h2);
    apb(1'b1, ADDR_CONN0, 32'h34);
    wfr(2);
    ln(0, 2'h0);
    server_signal_fail[0] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    st(1'b0);
    wfr(3);
    st(1'b1);
    ln(0, 2'h1);
    server_signal_fail[0] <= 1'b0;
    st(1'b1);
    wfr(3);
    st(1'b0);
    apb(1'b1, ADDR_PROT, 32'h00040045);
    server_signal_fail[0] <= 1'b1;
    wfr(3);
    st(1'b0);
    trail_signal_fail[0] <= 1'b1;
    wfr(3);
    st(1'b1);
    {trail_signal_fail[0], server_signal_fail[0]} <= 2'b00;
    trail_signal_degrade[0] <= 1'b1;
    wfr(4);
    st(1'b1);
    trail_signal_degrade[0] <= 1'b0;
    apb(1'b1, ADDR_CMD, 32'(CMD_BARRED));
    trail_signal_fail[0] <= 1'b1;
    wfr(4);
    st(1'b0);
    apb(1'b1, ADDR_CMD, 32'(CMD_CLEAR));
    wfr(3);
    st(1'b1);
    trail_signal_fail[0] <= 1'b0;
    wfr(4);
    st(1'b0);
    apb(1'b1, ADDR_CMD, 32'(CMD_FORCE_P));
    apb(1'b1, ADDR_CMD, 32'(CMD_MANUAL_W));
    wfr(3);
    st(1'b1);
    apb(1'b1, ADDR_PROT, 32'h00040042);
    apb(1'b1, ADDR_CMD, 32'(CMD_MANUAL_P));
    wfr(3);
    st(1'b1);
    apb(1'b1, ADDR_CMD, 32'(CMD_FORCE_W));
    wfr(3);
    st(1'b0);
    apb(1'b1, ADDR_CMD, 32'(CMD_CLEAR));
    trail_signal_fail[0] <= 1'b1;
    wfr(3);
    trail_signal_fail[0] <= 1'b0;
    wfr(4);
    st(1'b1);
    apb(1'b1, ADDR_CMD, 32'(CMD_MANUAL_W));
    wfr(3);
    st(1'b0);
    complete_run;
  end
endmodule
`default_nettype wire
